// ===== hdl/wss_pkg.sv
// Purpose: Shared constants for the word shift, subtract and store unit
// Assumes: 32-bit instruction words, 64-bit registers, 128-bit data bus
// Notes: Opcode and function codes follow the instruction encodings
package wss_pkg;
    localparam int unsigned WSS_XLEN = 64;
    localparam int unsigned WSS_WLEN = 32;
    localparam int unsigned WSS_BUS_W = 128;
    localparam int unsigned WSS_BE_W = 16;
    // Instruction field positions
    localparam int unsigned WSS_OPC_LSB = 26;
    localparam int unsigned WSS_SRCA_LSB = 21;
    localparam int unsigned WSS_SRCB_LSB = 16;
    localparam int unsigned WSS_DEST_LSB = 11;
    localparam int unsigned WSS_SHAMT_LSB = 6;
    localparam int unsigned WSS_IMM_W = 16;
    // Major opcodes
    localparam logic [5:0] WSS_OPC_SPECIAL = 6'h00;
    localparam logic [5:0] WSS_OPC_STORE_WORD = 6'h2b;
    // Function codes
    localparam logic [5:0] WSS_FN_LOGIC_RIGHT_IMM = 6'h02;
    localparam logic [5:0] WSS_FN_ARITH_RIGHT_IMM = 6'h03;
    localparam logic [5:0] WSS_FN_LOGIC_RIGHT_VAR = 6'h06;
    localparam logic [5:0] WSS_FN_ARITH_RIGHT_VAR = 6'h07;
    localparam logic [5:0] WSS_FN_MINUS_TRAP = 6'h22;
    localparam logic [5:0] WSS_FN_MINUS_WRAP = 6'h23;
    // Exception codes on the exception output
    typedef enum logic [2:0] {
        WSS_EXC_NONE = 3'h0,
        WSS_EXC_OVERFLOW = 3'h1,
        WSS_EXC_ADDR_ERROR = 3'h2,
        WSS_EXC_TLB_REFILL = 3'h3,
        WSS_EXC_TLB_INVALID = 3'h4,
        WSS_EXC_TLB_MODIFIED = 3'h5,
        WSS_EXC_RESERVED = 3'h6
    } wss_exc_t;
    // Operation selected by decode
    typedef enum logic [2:0] {
        WSS_OP_NONE,
        WSS_OP_SHIFT,
        WSS_OP_MINUS_TRAP,
        WSS_OP_MINUS_WRAP,
        WSS_OP_STORE
    } wss_op_t;
    localparam logic [63:0] WSS_RESULT_RESET = 64'h0;
endpackage : wss_pkg

// ===== hdl/wss_right_shift.sv
// Purpose: 32-bit word right shifter with sign-extended 64-bit result
// Assumes: Count already selected by the caller
// Notes: Purely combinational
`timescale 1ns/100ps
module wss_right_shift #(
    parameter int unsigned WORD_W = 32,
    parameter int unsigned CNT_W = 5
) (
    // Operands
    input wire logic [WORD_W-1:0] word_in,
    input wire logic [CNT_W-1:0] count_in,
    input wire logic arith_in,
    // Result
    output logic [2*WORD_W-1:0] result_out
);
    wire logic fill_bit;
    wire logic [2*WORD_W-1:0] wide_word;
    wire logic [2*WORD_W-1:0] shifted;
    wire logic [WORD_W-1:0] low_word;

    assign fill_bit = arith_in & word_in[WORD_W-1];
    assign wide_word = {{WORD_W{fill_bit}}, word_in};
    assign shifted = wide_word >> count_in;
    assign low_word = shifted[WORD_W-1:0];
    assign result_out = {{WORD_W{low_word[WORD_W-1]}}, low_word};
endmodule : wss_right_shift

// ===== hdl/wss_store_lane.sv
// Purpose: Places a store word on the 128-bit data bus
// Assumes: Address is already word aligned when used
// Notes: Byte enables mark the four written lanes
`timescale 1ns/100ps
module wss_store_lane #(
    parameter int unsigned WORD_W = 32,
    parameter int unsigned BUS_W = 128
) (
    // Placement inputs
    input wire logic [WORD_W-1:0] word_in,
    input wire logic [3:0] addr_low_in,
    input wire logic byte_order_big_in,
    // Bus image
    output logic [BUS_W-1:0] data_out,
    output logic [BUS_W/8-1:0] byte_en_out,
    output logic [3:0] lane_out
);
    wire logic [3:0] lane;
    wire logic [6:0] bit_shift;

    assign lane = addr_low_in ^ {{2{byte_order_big_in}}, 2'h0};
    assign bit_shift = {lane, 3'h0};
    assign data_out = {{(BUS_W-WORD_W){1'b0}}, word_in} << bit_shift;
    assign byte_en_out = {{(BUS_W/8-4){1'b0}}, 4'hf} << lane;
    assign lane_out = lane;
endmodule : wss_store_lane

// ===== hdl/wss_unit.sv
// Purpose: Word right shifts, word subtracts and store word for a 64-bit core
// Assumes: Decode supplies the instruction word and register operands each issue
// Notes: One cycle from issue to registered result, store request or exception
`timescale 1ns/100ps

// Summary of operation
// - Arithmetic right shifts fill vacated upper bits with bit 31.
// - Logical right shifts fill vacated upper bits with zero.
// - Immediate shift forms take distance from the 5-bit shift amount field.
// - Variable shift forms use only bits 4..0 of the first operand.
// - Shift results are sign-extended from bit 31 to 64 bits.
// - Shift result is unspecified when second operand is not a sign-extended word.
// - Trapping subtract overflow leaves destination unchanged and raises overflow.
// - Trapping subtract without overflow writes sign-extended 32-bit difference.
// - Wrapping subtract always writes modulo difference, never traps.
// - Subtract result unspecified when either source is not a sign-extended word.
// - Store address is sign-extended offset plus base bits 31..0.
// - Store writes only the low 32 bits of the second operand.
// - Nonzero address bits 1..0 raise address error and suppress the store.
// - Store reports TLB refill, invalid and modified from translation.
// - Variable arithmetic shift: opcode 000000, function 000111, zero shift field.
// - Immediate logical shift: opcode 000000, function 000010, bits 25..21 zero.
// - Variable logical shift: opcode 000000, function 000110, zero shift field.
// - Wrapping subtract: opcode 000000, function 100011, zero shift field.
// - Store word: opcode 101011 with base, source and 16-bit offset.
module wss_unit #(
    parameter int unsigned XLEN = wss_pkg::WSS_XLEN,
    parameter int unsigned BUS_W = wss_pkg::WSS_BUS_W
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Issue from decode
    input wire logic issue_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [XLEN-1:0] operand_a_reg_in,
    input wire logic [XLEN-1:0] operand_b_reg_in,
    input wire logic byte_order_big_in,
    // Address translation answer for the store address
    input wire logic tlb_refill_in,
    input wire logic tlb_invalid_in,
    input wire logic tlb_modified_in,
    // Translation lookup address
    output logic [31:0] xlate_addr_out,
    // Register file write
    output logic dest_we_out,
    output logic [4:0] dest_reg_out,
    output logic [XLEN-1:0] dest_data_out,
    // Data memory store
    output logic store_valid_out,
    output logic [31:0] store_addr_out,
    output logic [BUS_W-1:0] store_data_out,
    output logic [BUS_W/8-1:0] store_byte_en_out,
    // Exception report
    output logic exc_valid_out,
    output logic [2:0] exc_code_out,
    output logic [31:0] exc_addr_out,
    // Decode status
    output logic illegal_out
);
    // Instruction fields
    wire logic [5:0] opcode;
    wire logic [4:0] src_a_field;
    wire logic [4:0] dest_field;
    wire logic [4:0] shamt_field;
    wire logic [5:0] funct;
    wire logic [15:0] offset_field;
    wire logic is_special;

    assign opcode = instr_in[wss_pkg::WSS_OPC_LSB +: 6];
    assign src_a_field = instr_in[wss_pkg::WSS_SRCA_LSB +: 5];
    assign dest_field = instr_in[wss_pkg::WSS_DEST_LSB +: 5];
    assign shamt_field = instr_in[wss_pkg::WSS_SHAMT_LSB +: 5];
    assign funct = instr_in[5:0];
    assign offset_field = instr_in[wss_pkg::WSS_IMM_W-1:0];
    assign is_special = (opcode == wss_pkg::WSS_OPC_SPECIAL);

    // Decode
    wire logic dec_arith_right_imm_op;
    wire logic dec_arith_right_var_op;
    wire logic dec_logic_right_imm_op;
    wire logic dec_logic_right_var_op;
    wire logic dec_minus_trap_op;
    wire logic dec_minus_wrap_op;
    wire logic dec_store_word_op;

    assign dec_arith_right_imm_op = is_special && funct == wss_pkg::WSS_FN_ARITH_RIGHT_IMM
        && src_a_field == 5'h00;
    assign dec_arith_right_var_op = is_special && funct == wss_pkg::WSS_FN_ARITH_RIGHT_VAR
        && shamt_field == 5'h00;
    assign dec_logic_right_imm_op = is_special && funct == wss_pkg::WSS_FN_LOGIC_RIGHT_IMM
        && src_a_field == 5'h00;
    assign dec_logic_right_var_op = is_special && funct == wss_pkg::WSS_FN_LOGIC_RIGHT_VAR
        && shamt_field == 5'h00;
    assign dec_minus_trap_op = is_special && funct == wss_pkg::WSS_FN_MINUS_TRAP
        && shamt_field == 5'h00;
    assign dec_minus_wrap_op = is_special && funct == wss_pkg::WSS_FN_MINUS_WRAP
        && shamt_field == 5'h00;
    assign dec_store_word_op = (opcode == wss_pkg::WSS_OPC_STORE_WORD);

    wire logic dec_shift;
    wire logic dec_var_shift;
    wire logic dec_arith_shift;
    wire logic dec_any;

    assign dec_var_shift = dec_arith_right_var_op | dec_logic_right_var_op;
    assign dec_arith_shift = dec_arith_right_imm_op | dec_arith_right_var_op;
    assign dec_shift = dec_var_shift | dec_arith_right_imm_op | dec_logic_right_imm_op;
    assign dec_any = dec_shift | dec_minus_trap_op | dec_minus_wrap_op | dec_store_word_op;

    wss_pkg::wss_op_t op_sel;
    assign op_sel = !dec_any ? wss_pkg::WSS_OP_NONE
        : dec_shift ? wss_pkg::WSS_OP_SHIFT
        : dec_minus_trap_op ? wss_pkg::WSS_OP_MINUS_TRAP
        : dec_minus_wrap_op ? wss_pkg::WSS_OP_MINUS_WRAP
        : wss_pkg::WSS_OP_STORE;

    // Shift path
    wire logic [4:0] shift_count;
    wire logic [XLEN-1:0] shift_result;

    assign shift_count = dec_var_shift ? operand_a_reg_in[4:0] : shamt_field;

    wss_right_shift #(
        .WORD_W(32),
        .CNT_W(5)
    ) u_shift (
        .word_in(operand_b_reg_in[31:0]),
        .count_in(shift_count),
        .arith_in(dec_arith_shift),
        .result_out(shift_result)
    );

    // Subtract path
    wire logic [31:0] diff_word;
    wire logic diff_overflow;
    wire logic [XLEN-1:0] diff_result;

    assign diff_word = operand_a_reg_in[31:0] - operand_b_reg_in[31:0];
    assign diff_overflow = (operand_a_reg_in[31] != operand_b_reg_in[31])
        && (diff_word[31] != operand_a_reg_in[31]);
    assign diff_result = {{(XLEN-32){diff_word[31]}}, diff_word};

    // Store path
    wire logic [31:0] eff_addr;
    wire logic misaligned;
    wire logic [BUS_W-1:0] lane_data;
    wire logic [BUS_W/8-1:0] lane_be;

    assign eff_addr = operand_a_reg_in[31:0] + {{16{offset_field[15]}}, offset_field};
    assign misaligned = (eff_addr[1:0] != 2'h0);
    assign xlate_addr_out = eff_addr;

    wss_store_lane #(
        .WORD_W(32),
        .BUS_W(BUS_W)
    ) u_lane (
        .word_in(operand_b_reg_in[31:0]),
        .addr_low_in(eff_addr[3:0]),
        .byte_order_big_in(byte_order_big_in),
        .data_out(lane_data),
        .byte_en_out(lane_be),
        .lane_out()
    );

    // Store exception priority: alignment first, then translation
    logic [2:0] store_exc;
    always_comb begin
        store_exc = wss_pkg::WSS_EXC_NONE;
        if (misaligned) begin
            store_exc = wss_pkg::WSS_EXC_ADDR_ERROR;
        end else if (tlb_refill_in) begin
            store_exc = wss_pkg::WSS_EXC_TLB_REFILL;
        end else if (tlb_invalid_in) begin
            store_exc = wss_pkg::WSS_EXC_TLB_INVALID;
        end else if (tlb_modified_in) begin
            store_exc = wss_pkg::WSS_EXC_TLB_MODIFIED;
        end
    end

    // Next state selection
    logic we_next;
    logic [XLEN-1:0] data_next;
    logic st_next;
    logic [2:0] exc_next;

    always_comb begin
        we_next = 1'b0;
        data_next = wss_pkg::WSS_RESULT_RESET;
        st_next = 1'b0;
        exc_next = wss_pkg::WSS_EXC_NONE;
        if (issue_valid_in) begin
            case (op_sel)
                wss_pkg::WSS_OP_SHIFT: begin
                    we_next = 1'b1;
                    data_next = shift_result;
                end
                wss_pkg::WSS_OP_MINUS_TRAP: begin
                    we_next = !diff_overflow;
                    data_next = diff_result;
                    exc_next = diff_overflow ? wss_pkg::WSS_EXC_OVERFLOW : wss_pkg::WSS_EXC_NONE;
                end
                wss_pkg::WSS_OP_MINUS_WRAP: begin
                    we_next = 1'b1;
                    data_next = diff_result;
                end
                wss_pkg::WSS_OP_STORE: begin
                    st_next = (store_exc == wss_pkg::WSS_EXC_NONE);
                    exc_next = store_exc;
                end
                default: begin
                    we_next = 1'b0;
                end
            endcase
        end
    end

    // Output registers
    logic dest_we_reg;
    logic [4:0] dest_reg_reg;
    logic [XLEN-1:0] dest_data_reg;
    logic store_valid_reg;
    logic [31:0] store_addr_reg;
    logic [BUS_W-1:0] store_data_reg;
    logic [BUS_W/8-1:0] store_be_reg;
    logic [2:0] exc_code_reg;
    logic [31:0] exc_addr_reg;
    logic illegal_reg;

    // Register file write
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            dest_we_reg <= 1'b0;
        end else begin
            dest_we_reg <= we_next;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            dest_reg_reg <= 5'h00;
        end else begin
            dest_reg_reg <= dest_field;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            dest_data_reg <= wss_pkg::WSS_RESULT_RESET;
        end else begin
            dest_data_reg <= data_next;
        end
    end

    // Data memory store
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            store_valid_reg <= 1'b0;
        end else begin
            store_valid_reg <= st_next;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            store_addr_reg <= 32'h0;
        end else begin
            store_addr_reg <= eff_addr;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            store_data_reg <= '0;
        end else begin
            store_data_reg <= st_next ? lane_data : '0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            store_be_reg <= '0;
        end else begin
            store_be_reg <= st_next ? lane_be : '0;
        end
    end

    // Exception report
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            exc_code_reg <= wss_pkg::WSS_EXC_NONE;
        end else begin
            exc_code_reg <= exc_next;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            exc_addr_reg <= 32'h0;
        end else begin
            exc_addr_reg <= eff_addr;
        end
    end

    // Decode status
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            illegal_reg <= 1'b0;
        end else begin
            illegal_reg <= issue_valid_in && !dec_any;
        end
    end

    assign dest_we_out = dest_we_reg;
    assign dest_reg_out = dest_reg_reg;
    assign dest_data_out = dest_data_reg;
    assign store_valid_out = store_valid_reg;
    assign store_addr_out = store_addr_reg;
    assign store_data_out = store_data_reg;
    assign store_byte_en_out = store_be_reg;
    assign exc_valid_out = (exc_code_reg != wss_pkg::WSS_EXC_NONE);
    assign exc_code_out = exc_code_reg;
    assign exc_addr_out = exc_addr_reg;
    assign illegal_out = illegal_reg;
endmodule : wss_unit

// ===== verification/wss_unit_assertions.sv
// Purpose: Port-level checks for the word shift, subtract and store unit
// Assumes: One cycle from issue to registered answer
// Notes: Bound to the unit from the bench top
`timescale 1ns/100ps
module wss_unit_checker #(
    parameter int unsigned XLEN = 64,
    parameter int unsigned BUS_W = 128
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Issue
    input wire logic issue_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [XLEN-1:0] operand_a_reg_in,
    input wire logic [XLEN-1:0] operand_b_reg_in,
    input wire logic byte_order_big_in,
    input wire logic tlb_refill_in,
    input wire logic tlb_invalid_in,
    input wire logic tlb_modified_in,
    // Answers
    input wire logic [31:0] xlate_addr_out,
    input wire logic dest_we_out,
    input wire logic [4:0] dest_reg_out,
    input wire logic [XLEN-1:0] dest_data_out,
    input wire logic store_valid_out,
    input wire logic [31:0] store_addr_out,
    input wire logic [BUS_W-1:0] store_data_out,
    input wire logic [BUS_W/8-1:0] store_byte_en_out,
    input wire logic exc_valid_out,
    input wire logic [2:0] exc_code_out,
    input wire logic [31:0] exc_addr_out,
    input wire logic illegal_out
);
    wire logic sp = issue_valid_in && instr_in[31:26] == 6'h00;
    wire logic [5:0] fn = instr_in[5:0];
    wire logic sh0 = instr_in[10:6] == 5'h00;
    wire logic [31:0] diff = operand_a_reg_in[31:0] - operand_b_reg_in[31:0];
    wire logic ovf = (operand_a_reg_in[31] != operand_b_reg_in[31]) && (diff[31] != operand_a_reg_in[31]);
    wire logic is_trap = sp && fn == 6'h22 && sh0;
    wire logic is_wrap = sp && fn == 6'h23 && sh0;
    wire logic is_arith_var = sp && fn == 6'h07 && sh0;
    wire logic is_arith_imm = sp && fn == 6'h03 && instr_in[25:21] == 5'h00;
    wire logic is_shift = is_arith_var || is_arith_imm || (sp && (fn == 6'h02 || fn == 6'h06));
    wire logic [31:0] arith_imm_exp = $signed(operand_b_reg_in[31:0]) >>> instr_in[10:6];
    wire logic [31:0] arith_var_exp = $signed(operand_b_reg_in[31:0]) >>> operand_a_reg_in[4:0];
    wire logic is_st = issue_valid_in && instr_in[31:26] == 6'h2b;
    wire logic [31:0] st_addr = operand_a_reg_in[31:0] + {{16{instr_in[15]}}, instr_in[15:0]};
    wire logic st_ok = is_st && st_addr[1:0] == 2'h0;
    wire logic any_tlb = tlb_refill_in || tlb_invalid_in || tlb_modified_in;
    wire logic [3:0] lane = st_addr[3:0] ^ {byte_order_big_in, byte_order_big_in, 2'h0};

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);

    sequence s_write_ok;
        dest_we_out && !exc_valid_out;
    endsequence
    sequence s_exc(logic [2:0] c);
        exc_valid_out && exc_code_out == c && !dest_we_out && !store_valid_out;
    endsequence

    AST_SEXT_RESULT: assert property (dest_we_out |-> dest_data_out[63:32] == {32{dest_data_out[31]}})
        else $error("result not sign extended");
    AST_ARITH_IMM: assert property (is_arith_imm |=> s_write_ok ##0 dest_data_out[31:0] == $past(arith_imm_exp))
        else $error("immediate arithmetic shift wrong");
    AST_ARITH_VAR: assert property (is_arith_var |=> s_write_ok ##0 dest_data_out[31:0] == $past(arith_var_exp))
        else $error("variable arithmetic shift wrong");
    AST_TRAP_OVF: assert property (is_trap && ovf |=> s_exc(3'h1))
        else $error("overflow not trapped");
    AST_TRAP_OK: assert property (is_trap && !ovf |=> s_write_ok ##0 dest_data_out[31:0] == $past(diff))
        else $error("trapping difference wrong");
    AST_WRAP_DIFF: assert property (is_wrap |=> s_write_ok ##0 dest_data_out[31:0] == $past(diff))
        else $error("wrapping difference wrong");
    AST_NO_EXC: assert property (is_shift || is_wrap |=> !exc_valid_out)
        else $error("exception from shift or wrap");
    AST_XLATE_ADDR: assert property (is_st |-> xlate_addr_out == st_addr)
        else $error("effective address wrong");
    AST_MISALIGN: assert property (is_st && st_addr[1:0] != 2'h0 |=> s_exc(3'h2))
        else $error("misaligned store not refused");
    AST_TLB_REFILL: assert property (st_ok && tlb_refill_in |=> s_exc(3'h3))
        else $error("refill fault not reported");
    AST_STORE_LANE: assert property (st_ok && !any_tlb |=> store_valid_out &&
        store_addr_out == $past(st_addr) && store_byte_en_out == 16'hf << $past(lane))
        else $error("store lane wrong");
endmodule : wss_unit_checker

// ===== verification/wss_far_model.sv
// Purpose: Address translation stand-in at the unit's far side
// Assumes: Bench picks the fault for each store
// Notes: Answers in the same cycle as the lookup
`timescale 1ns/100ps
module wss_far_model (
    // Lookup
    input wire logic [31:0] xlate_addr_in,
    input wire logic [1:0] fault_sel_in,
    // Faults
    output logic tlb_refill_out,
    output logic tlb_invalid_out,
    output logic tlb_modified_out
);
    // Faults only for the low 2 GB window, none elsewhere
    wire logic in_win = !xlate_addr_in[31];
    assign tlb_refill_out = in_win && fault_sel_in == 2'h1;
    assign tlb_invalid_out = in_win && fault_sel_in == 2'h2;
    assign tlb_modified_out = in_win && fault_sel_in == 2'h3;
endmodule : wss_far_model

// ===== verification/tb_word_shift_sub_store_unit.sv
// Purpose: Self-checking bench for the word shift, subtract and store unit
// Assumes: Inputs change at the falling edge
// Notes: One task per scenario
`timescale 1ns/100ps
module tb_word_shift_sub_store_unit;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issue = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [63:0] op_a = 64'h0;
    logic [63:0] op_b = 64'h0;
    logic big = 1'b0;
    logic [1:0] fault_sel = 2'h0;
    logic refill, invalid, modified, dest_we, st_v, exc_v, illegal;
    logic [31:0] xlate, st_addr, exc_addr;
    logic [4:0] dest_reg;
    logic [63:0] dest_data;
    logic [127:0] st_data;
    logic [15:0] st_be;
    logic [2:0] exc_code;
    int n_mismatch = 0;
    int comparisons = 0;

    always #20 clk = ~clk;

    wss_far_model u_far (.xlate_addr_in(xlate), .fault_sel_in(fault_sel), .tlb_refill_out(refill),
        .tlb_invalid_out(invalid), .tlb_modified_out(modified));
    wss_unit DUT (.clock_in(clk), .reset_in(rst), .issue_valid_in(issue), .instr_in(instr),
        .operand_a_reg_in(op_a), .operand_b_reg_in(op_b), .byte_order_big_in(big),
        .tlb_refill_in(refill), .tlb_invalid_in(invalid), .tlb_modified_in(modified),
        .xlate_addr_out(xlate), .dest_we_out(dest_we), .dest_reg_out(dest_reg), .dest_data_out(dest_data),
        .store_valid_out(st_v), .store_addr_out(st_addr), .store_data_out(st_data),
        .store_byte_en_out(st_be), .exc_valid_out(exc_v), .exc_code_out(exc_code),
        .exc_addr_out(exc_addr), .illegal_out(illegal));

    task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [63:0] sx(input logic [31:0] w);
        return {{32{w[31]}}, w};
    endfunction : sx

    // Present one instruction, return at the falling edge after it was taken
    task automatic run_op(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
        instr = ins;
        op_a = a;
        op_b = b;
        issue = 1'b1;
        @(negedge clk);
    endtask : run_op

    task automatic idle();
        issue = 1'b0;
        @(negedge clk);
    endtask : idle

    task automatic test_shifts();
        logic [5:0] fns [4] = '{6'h03, 6'h02, 6'h07, 6'h06};
        logic [4:0] cnts [3] = '{5'h00, 5'h04, 5'h1f};
        logic [31:0] w;
        logic [31:0] e;
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 4; i++) begin
                w = 32'h8000_00f0;
                e = fns[i][0] ? 32'($signed(w) >>> cnts[k]) : w >> cnts[k];
                if (i < 2) begin
                    run_op({6'h00, 5'h00, 5'h02, 5'h03, cnts[k], fns[i]}, 64'h0, sx(w));
                end else begin
                    run_op({6'h00, 5'h01, 5'h02, 5'h03, 5'h00, fns[i]}, {59'h7ff_ffff_ffff_fffe, cnts[k]}, sx(w));
                end
                check("shift_data", 128'(sx(e)), 128'(dest_data));
                check("shift_we_reg", 128'h23, {122'h0, dest_we, dest_reg});
                check("shift_exc", 128'h0, 128'(exc_v));
            end
        end
        idle();
        $display("test_shifts done");
    endtask : test_shifts

    task automatic test_subs();
        run_op({6'h00, 5'h01, 5'h02, 5'h04, 5'h00, 6'h22}, 64'h5, 64'h7);
        check("trap_data", {63'h0, 1'b1, sx(32'hffff_fffe)}, {63'h0, dest_we, dest_data});
        run_op({6'h00, 5'h01, 5'h02, 5'h04, 5'h00, 6'h22}, sx(32'h8000_0000), 64'h1);
        check("trap_ovf", 128'h9, {123'h0, dest_we, exc_v, exc_code});
        run_op({6'h00, 5'h01, 5'h02, 5'h04, 5'h00, 6'h23}, sx(32'h8000_0000), 64'h1);
        check("wrap_data", 128'(sx(32'h7fff_ffff)), 128'(dest_data));
        check("wrap_exc", 128'h2, {126'h0, dest_we, exc_v});
        idle();
        $display("test_subs done");
    endtask : test_subs

    task automatic test_store();
        logic [15:0] offs [6] = '{16'hfff8, 16'h0008, 16'h0009, 16'h0008, 16'h0008, 16'h0008};
        logic [31:0] ea;
        logic [3:0] ln;
        for (int i = 0; i < 6; i++) begin
            big = (i == 1);
            fault_sel = (i > 2) ? 2'(i - 2) : 2'h0;
            ea = 32'h0000_1004 + {{16{offs[i][15]}}, offs[i]};
            ln = ea[3:0] ^ {big, big, 2'h0};
            run_op({6'h2b, 5'h01, 5'h02, offs[i]}, 64'h1004, 64'h1234_5678_cafe_babe);
            if (i < 2) begin
                check("store_addr", 128'(ea), 128'(st_addr));
                check("store_data", 128'hcafe_babe << (8 * ln), st_data);
                check("store_be", 128'(16'hf << ln), 128'(st_be));
                check("store_valid", 128'h2, {126'h0, st_v, exc_v});
            end else begin
                check("store_exc", 128'(i), {124'h0, st_v, exc_code});
                check("exc_addr", 128'(ea), 128'(exc_addr));
            end
        end
        idle();
        fault_sel = 2'h0;
        $display("test_store done");
    endtask : test_store

    task automatic test_illegal();
        run_op({6'h00, 5'h01, 5'h02, 5'h03, 5'h02, 6'h02}, 64'h0, 64'h8);
        check("illegal", 128'h2, {126'h0, illegal, dest_we});
        idle();
        $display("test_illegal done");
    endtask : test_illegal

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #(40 * 500);
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        test_shifts();
        test_subs();
        test_store();
        test_illegal();
        finish_test();
    end
endmodule : tb_word_shift_sub_store_unit

bind wss_unit wss_unit_checker #(.XLEN(XLEN), .BUS_W(BUS_W)) u_chk (.clock_in(clock_in), .reset_in(reset_in),
    .issue_valid_in(issue_valid_in), .instr_in(instr_in), .operand_a_reg_in(operand_a_reg_in),
    .operand_b_reg_in(operand_b_reg_in), .byte_order_big_in(byte_order_big_in), .tlb_refill_in(tlb_refill_in),
    .tlb_invalid_in(tlb_invalid_in), .tlb_modified_in(tlb_modified_in), .xlate_addr_out(xlate_addr_out),
    .dest_we_out(dest_we_out), .dest_reg_out(dest_reg_out), .dest_data_out(dest_data_out),
    .store_valid_out(store_valid_out), .store_addr_out(store_addr_out), .store_data_out(store_data_out),
    .store_byte_en_out(store_byte_en_out), .exc_valid_out(exc_valid_out), .exc_code_out(exc_code_out),
    .exc_addr_out(exc_addr_out), .illegal_out(illegal_out));
